// *** hw/idu_top.sv ***
`include "idu_params.svh"
`default_nettype none
// ==========================================================
// Overview of operation
// RQ1: Byte divide: quotient low, remainder high byte
// RQ2: Word divides take whole word dividend
// RQ3: Dword divides read aligned pair dividend
// RQ4: Register pairs are even-odd aligned
// RQ5: Quotient low half, remainder high half
// RQ6: Carry always cleared by divide
// RQ7: Byte divide: V set only on zero
// RQ8: Byte divide by zero raises trap
// RQ9: Word divides: V when quotient exceeds 8
// RQ10: Dword divides: V when quotient exceeds 16
// RQ11: N and Z from quotient only
// RQ12: Divisor is half the destination width
// RQ13: Signed word register form: 14 clocks
// RQ14: Signed word immediate: 3 bytes, 14 clocks
// RQ15: Signed dword: 24 clocks, 2/4 bytes
// RQ16: Immediate 16: byte 3 upper, byte 4 lower
// RQ17: Byte divide: low byte dividend, 12 clocks
// RQ18: Unsigned word immediate: 3 bytes, 12
// RQ19: Unsigned dword: 22 clocks, pair write
// RQ20: Unsigned dword also has immediate form
// RQ21: Destination on overflow is implementation choice
module idu_top #(
   parameter int ADDR_W = 6 // AXI byte address width
)(
   // Clock and reset
   input  wire logic              clk_sys,
   input  wire logic              nrst,
   // AXI4-Lite write address and data
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   // AXI4-Lite read
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   // Core side
   output idu_pkg::idu_state_t    divState,
   output logic                   divTrap
);
   import idu_pkg::*;

   // Fewer address bits cannot reach the register file
   if (ADDR_W < 6)
      $error("idu_top: ADDR_W must be at least 6");

   logic              awFull;   // Write address held
   logic [ADDR_W-1:0] awAddr;   // Held write address
   logic              wFull;    // Write data held
   logic [31:0]       wData;    // Held write data
   logic [3:0]        wStrb;    // Held byte enables
   logic [3:0]        awIdx;    // Word index of write
   logic              wrDo;     // Both halves present
   logic              wrErr;    // Write refused
   logic              startOp;  // Command accepted
   logic              regWr;    // Software register write
   logic [15:0]       regs [8]; // Register file R0..R7
   logic [15:0]       imm;      // Bytes 3 and 4 of the opcode
   idu_op_t           opQ;      // Kind in flight
   logic              immQ;     // Immediate form in flight
   logic [2:0]        dstQ;     // Destination word
   logic [3:0]        srcQ;     // Divisor register
   logic [2:0]        lenQ;     // Instruction length
   logic [4:0]        cnt;      // Clocks left
   logic              done;     // Last clock of a divide
   logic              wideQ;    // 32-by-16 in flight
   logic              flagC;
   logic              flagV;
   logic              flagN;
   logic              flagZ;
   logic              trapped;  // Last divide trapped
   logic [2:0]        wbIdx;    // Quotient word target
   logic [15:0]       wbData;   // Quotient word value
   logic              next_wide;
   logic [2:0]        next_dst;
   logic [31:0]       next_dividend;
   logic [15:0]       next_divisor;
   logic [15:0]       srcByteWord;
   logic [4:0]        next_cnt;
   logic [31:0]       rdWord;
   logic              rdErr;
   logic [3:0]        arIdx;

   idu_div_if dv ();

   // ==========================================================
   // Write channel: address and data taken in either order
   assign s_axi_awready = !awFull;
   assign s_axi_wready  = !wFull;
   assign wrDo  = awFull && wFull && !s_axi_bvalid;
   assign awIdx = awAddr[5:2];

   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         awFull <= 1'b0;
         awAddr <= '0;
      end
      else if (s_axi_awvalid && s_axi_awready)
      begin
         awFull <= 1'b1;
         awAddr <= s_axi_awaddr;
      end
      else if (wrDo)
         awFull <= 1'b0;
   end

   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         wFull <= 1'b0;
         wData <= 32'h0;
         wStrb <= 4'h0;
      end
      else if (s_axi_wvalid && s_axi_wready)
      begin
         wFull <= 1'b1;
         wData <= s_axi_wdata;
         wStrb <= s_axi_wstrb;
      end
      else if (wrDo)
         wFull <= 1'b0;
   end

   // ==========================================================
   // Write decode; nothing is written while a divide runs,
   // so the register file never sees two writers at once
   always_comb
   begin
      wrErr = (awAddr >> 6) != '0;
      if (divState == IDU_RUN || awIdx == `IDU_IDX_STAT)
         wrErr = 1'b1;
      else if (awIdx == `IDU_IDX_CMD)
         wrErr = wData[2:0] > IDU_SIGNED_DWORD_BY_WORD_DIVIDE;
      else if (awIdx != `IDU_IDX_IMM && !awIdx[3])
         wrErr = 1'b1;
   end
   assign startOp = wrDo && !wrErr && awIdx == `IDU_IDX_CMD &&
                    wStrb[0];
   assign regWr   = wrDo && !wrErr && awIdx[3];

   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= 2'b00;
      end
      else if (wrDo)
      begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= wrErr ? 2'b10 : 2'b00; // SLVERR
      end
      else if (s_axi_bready)
         s_axi_bvalid <= 1'b0;
   end

   // ==========================================================
   // Immediate bytes: byte 3 low lane, byte 4 next lane
   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
         imm <= `IDU_IMM_RST;
      else if (wrDo && !wrErr && awIdx == `IDU_IDX_IMM)
      begin
         if (wStrb[0])
            imm[7:0] <= wData[7:0];
         if (wStrb[1])
            imm[15:8] <= wData[15:8];
      end
   end

   // ==========================================================
   // Operand fetch from the command word
   always_comb
   begin
      next_wide = wData[2:0] == IDU_UNSIGNED_DWORD_BY_WORD_DIVIDE ||
                  wData[2:0] == IDU_SIGNED_DWORD_BY_WORD_DIVIDE;
      // Pairs start on an even word [RQ4]
      next_dst = next_wide ? {wData[6:5], 1'b0} : wData[6:4];
      // Odd word holds the high half of the pair [RQ3]
      next_dividend = next_wide
                    ? {regs[{next_dst[2:1], 1'b1}], regs[next_dst]}
                    : {16'h0, regs[next_dst]};
      srcByteWord = regs[wData[11:9]];
      if (wData[3])
         // Byte 3 is the upper half of a 16-bit divisor [RQ16]
         next_divisor = next_wide ? {imm[7:0], imm[15:8]}
                                  : {8'h0, imm[7:0]};
      else if (next_wide)
         next_divisor = regs[wData[10:8]];
      else // Byte register: odd index is the high byte [RQ12]
         next_divisor = {8'h0, wData[8] ? srcByteWord[15:8]
                                        : srcByteWord[7:0]};
      // Clock count less two: the issue cycle and the cycle at zero
      case (wData[2:0])
         3'h0:    next_cnt = 5'(`IDU_CLK_UBB - 2); // [RQ17]
         3'h1:    next_cnt = 5'(`IDU_CLK_UWB - 2); // [RQ18]
         3'h2:    next_cnt = 5'(`IDU_CLK_SWB - 2); // [RQ13] [RQ14]
         3'h3:    next_cnt = 5'(`IDU_CLK_UDW - 2); // [RQ19] [RQ20]
         default: next_cnt = 5'(`IDU_CLK_SDW - 2); // [RQ15]
      endcase
   end

   // ==========================================================
   // Command latch and operands to the core
   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         opQ         <= IDU_UNSIGNED_BYTE_BY_BYTE_DIVIDE;
         immQ        <= 1'b0;
         dstQ        <= 3'h0;
         srcQ        <= 4'h0;
         lenQ        <= `IDU_LEN_REG;
         dv.op       <= IDU_UNSIGNED_BYTE_BY_BYTE_DIVIDE;
         dv.dividend <= 32'h0;
         dv.divisor  <= 16'h0;
      end
      else if (startOp)
      begin
         opQ         <= idu_op_t'(wData[2:0]);
         immQ        <= wData[3];
         dstQ        <= next_dst;
         srcQ        <= wData[11:8];
         // Immediate adds one or two bytes [RQ14] [RQ15] [RQ18]
         lenQ        <= !wData[3] ? `IDU_LEN_REG
                      : next_wide ? `IDU_LEN_IMM16 : `IDU_LEN_IMM8;
         dv.op       <= idu_op_t'(wData[2:0]);
         dv.dividend <= next_dividend;
         dv.divisor  <= next_divisor;
      end
   end

   // ==========================================================
   // Sequencer: idle until a command, then a fixed count
   assign done  = divState == IDU_RUN && cnt == 5'h0;
   assign wideQ = opQ == IDU_UNSIGNED_DWORD_BY_WORD_DIVIDE ||
                  opQ == IDU_SIGNED_DWORD_BY_WORD_DIVIDE;

   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         divState <= IDU_IDLE;
         cnt      <= 5'h0;
      end
      else
         case (divState)
            IDU_IDLE:
               if (startOp)
               begin
                  divState <= IDU_RUN;
                  cnt      <= next_cnt;
               end
            IDU_RUN:
               if (cnt == 5'h0)
                  divState <= IDU_IDLE;
               else
                  cnt <= cnt - 5'h1;
            default:
               divState <= IDU_IDLE;
         endcase
   end

   // ==========================================================
   // Write-back: quotient in the low half, remainder high
   // Byte lanes pack as {remainder, quotient} [RQ1] [RQ5]
   assign wbIdx  = dstQ;
   assign wbData = wideQ ? dv.quot : {dv.rem[7:0], dv.quot[7:0]};

   for (genvar i = 0; i < 8; i++)
   begin : g_reg
      always_ff @(posedge clk_sys or negedge nrst)
      begin
         if (!nrst)
            regs[i] <= `IDU_REG_RST;
         // Overflow leaves the destination untouched [RQ21]
         else if (done && !dv.ovf && i == int'(wbIdx))
            regs[i] <= wbData;                         // [RQ5]
         else if (done && !dv.ovf && wideQ &&
                  i == int'({wbIdx[2:1], 1'b1}))
            regs[i] <= dv.rem;                         // [RQ19]
         else if (regWr && i == int'(awIdx[2:0]))
         begin
            if (wStrb[0])
               regs[i][7:0] <= wData[7:0];
            if (wStrb[1])
               regs[i][15:8] <= wData[15:8];
         end
      end
   end

   // ==========================================================
   // Flags and trap at completion
   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         flagC   <= 1'b0;
         flagV   <= 1'b0;
         flagN   <= 1'b0;
         flagZ   <= 1'b0;
         trapped <= 1'b0;
         divTrap <= 1'b0;
      end
      else
      begin
         divTrap <= 1'b0;
         if (startOp)
            trapped <= 1'b0;
         if (done)
         begin
            flagC <= 1'b0;                             // [RQ6]
            flagV <= dv.ovf;                   // [RQ7] [RQ9] [RQ10]
            // Remainder never reaches N or Z [RQ11]
            flagN <= wideQ ? dv.quot[15] : dv.quot[7];
            flagZ <= wideQ ? dv.quot == 16'h0 : dv.quot[7:0] == 8'h0;
            // Only the byte kind traps on zero [RQ8]
            if (opQ == IDU_UNSIGNED_BYTE_BY_BYTE_DIVIDE && dv.ovf)
            begin
               divTrap <= 1'b1;
               trapped <= 1'b1;
            end
         end
      end
   end

   // ==========================================================
   // Read channel: one word per request, answered next cycle
   assign s_axi_arready = !s_axi_rvalid;
   assign arIdx = s_axi_araddr[5:2];

   always_comb
   begin
      rdWord = 32'h0;
      rdErr  = (s_axi_araddr >> 6) != '0;
      if (arIdx[3])
         rdWord = {16'h0, regs[arIdx[2:0]]};
      else if (arIdx == `IDU_IDX_CMD)
         rdWord = {20'h0, srcQ, 1'b0, dstQ, immQ, opQ};
      else if (arIdx == `IDU_IDX_IMM)
         rdWord = {16'h0, imm};
      else if (arIdx == `IDU_IDX_STAT)
      begin
         rdWord[`IDU_ST_BUSY]  = divState == IDU_RUN;
         rdWord[`IDU_ST_C]     = flagC;
         rdWord[`IDU_ST_V]     = flagV;
         rdWord[`IDU_ST_N]     = flagN;
         rdWord[`IDU_ST_Z]     = flagZ;
         rdWord[`IDU_ST_TRAP]  = trapped;
         rdWord[`IDU_ST_LEN+:3] = lenQ;
      end
      else
         rdErr = 1'b1;
      if (rdErr)
         rdWord = 32'h0;
   end

   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0;
         s_axi_rresp  <= 2'b00;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= rdWord;
         s_axi_rresp  <= rdErr ? 2'b10 : 2'b00;
      end
      else if (s_axi_rready)
         s_axi_rvalid <= 1'b0;
   end

   idu_divider idu_divider_inst (
      .clk_sys (clk_sys),
      .nrst    (nrst),
      .dv      (dv)
   );

   // ==========================================================
   // Checks
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!nrst);

   sequence s_issue(logic [2:0] k);
      startOp && wData[2:0] == k;
   endsequence

   a_lat_ubyte: assert property (s_issue(3'h0) |-> ##11 done) // [RQ17]
      else $error("byte divide not done in 12 clocks");
   a_lat_uword: assert property (s_issue(3'h1) |-> ##11 done) // [RQ18]
      else $error("unsigned word divide not 12 clocks");
   a_lat_sword: assert property (s_issue(3'h2) |-> ##13 done) // [RQ13]
      else $error("signed word divide not 14 clocks");
   a_lat_udword: assert property (s_issue(3'h3) |-> ##21 done) // [RQ19]
      else $error("unsigned dword divide not 22 clocks");
   a_lat_sdword: assert property (s_issue(3'h4) |-> ##23 done) // [RQ15]
      else $error("signed dword divide not 24 clocks");
   a_carry_clear: assert property (done |=> !flagC) // [RQ6]
      else $error("carry left set after divide");
   a_trap_zero: assert property (                            // [RQ8]
      done && opQ == IDU_UNSIGNED_BYTE_BY_BYTE_DIVIDE |=>
      divTrap == (dv.divisor[7:0] == 8'h0))
      else $error("trap does not match zero divisor");
   a_uword_ovf: assert property (                            // [RQ9]
      done && opQ == IDU_UNSIGNED_WORD_BY_BYTE_DIVIDE &&
      dv.divisor[7:0] != 8'h0 |=>
      flagV == (dv.dividend[15:8] >= dv.divisor[7:0]))
      else $error("word overflow flag wrong");
   a_udword_ovf: assert property (                           // [RQ10]
      done && opQ == IDU_UNSIGNED_DWORD_BY_WORD_DIVIDE &&
      dv.divisor != 16'h0 |=>
      flagV == (dv.dividend[31:16] >= dv.divisor))
      else $error("dword overflow flag wrong");
   a_zero_quot: assert property (                            // [RQ11]
      done && wideQ |=> flagZ == ($past(dv.quot) == 16'h0))
      else $error("zero flag not from quotient");
   a_pair_rem: assert property (                             // [RQ19]
      done && wideQ && !dv.ovf |=>
      regs[{dstQ[2:1], 1'b1}] == $past(dv.rem))
      else $error("remainder not in odd pair word");
   a_imm_len: assert property (                              // [RQ14]
      startOp && wData[3] && !next_wide |=> lenQ == 3'h3)
      else $error("immediate length wrong");
endmodule
`default_nettype wire

// *** hw/idu_params.svh ***
`ifndef IDU_PARAMS_SVH
`define IDU_PARAMS_SVH
// ==========================================================
// Register word indexes (byte address = index * 4)
`define IDU_IDX_CMD   4'h0
`define IDU_IDX_IMM   4'h1
`define IDU_IDX_STAT  4'h2
// Register file words R0..R7 sit at indexes 8..15
`define IDU_IDX_REGB  4'h8
// ==========================================================
// Status word bit positions
`define IDU_ST_BUSY   0
`define IDU_ST_C      1
`define IDU_ST_V      2
`define IDU_ST_N      3
`define IDU_ST_Z      4
`define IDU_ST_TRAP   5
`define IDU_ST_LEN    8
// ==========================================================
// Reset values
`define IDU_IMM_RST   16'h0000
`define IDU_REG_RST   16'h0000
// ==========================================================
// Completion times in core clocks, per divide kind
`define IDU_CLK_UBB   12
`define IDU_CLK_UWB   12
`define IDU_CLK_SWB   14
`define IDU_CLK_UDW   22
`define IDU_CLK_SDW   24
// Instruction lengths in bytes
`define IDU_LEN_REG   3'h2
`define IDU_LEN_IMM8  3'h3
`define IDU_LEN_IMM16 3'h4
`endif

// *** hw/idu_pkg.sv ***
`default_nettype none
// ==========================================================
// Types shared by the divide unit
package idu_pkg;
   // Divide kinds, as coded in the command word
   typedef enum logic [2:0]
   {
      IDU_UNSIGNED_BYTE_BY_BYTE_DIVIDE  = 3'h0,
      IDU_UNSIGNED_WORD_BY_BYTE_DIVIDE  = 3'h1,
      IDU_SIGNED_WORD_BY_BYTE_DIVIDE    = 3'h2,
      IDU_UNSIGNED_DWORD_BY_WORD_DIVIDE = 3'h3,
      IDU_SIGNED_DWORD_BY_WORD_DIVIDE   = 3'h4
   } idu_op_t;
   // Sequencer states, one-hot
   typedef enum logic [1:0]
   {
      IDU_IDLE = 2'b01,
      IDU_RUN  = 2'b10
   } idu_state_t;
endpackage
`default_nettype wire

// *** hw/idu_div_if.sv ***
`default_nettype none
// ==========================================================
// Operands to the arithmetic core and its results
interface idu_div_if;
   import idu_pkg::*;
   logic [31:0] dividend;  // Zero-extended per kind
   logic [15:0] divisor;   // Low byte only for byte divisors
   idu_op_t     op;        // Divide kind
   logic [15:0] quot;      // Quotient, registered
   logic [15:0] rem;       // Remainder, registered
   logic        ovf;       // Zero divisor or quotient too wide
   modport issuer (output dividend, divisor, op,
                   input  quot, rem, ovf);
   modport core   (input  dividend, divisor, op,
                   output quot, rem, ovf);
endinterface
`default_nettype wire

// *** hw/idu_divider.sv ***
`default_nettype none
// ==========================================================
// Arithmetic core: one cycle from operands to registered result
module idu_divider (
   // Clock and reset
   input  wire logic clk_sys,
   input  wire logic nrst,
   // Operands and results
   idu_div_if.core   dv
);
   import idu_pkg::*;

   logic               sgn;   // Signed kind
   logic               wide;  // 32-by-16 kind
   logic               ubyte; // 8-by-8 kind
   logic signed [33:0] a;     // Extended dividend
   logic signed [33:0] b;     // Extended divisor
   logic signed [33:0] q;     // Full quotient
   logic signed [33:0] r;     // Full remainder
   logic               next_ovf;

   // ==========================================================
   // Operand extension and division
   always_comb
   begin
      sgn   = (dv.op == IDU_SIGNED_WORD_BY_BYTE_DIVIDE) ||
              (dv.op == IDU_SIGNED_DWORD_BY_WORD_DIVIDE);
      wide  = (dv.op == IDU_UNSIGNED_DWORD_BY_WORD_DIVIDE) ||
              (dv.op == IDU_SIGNED_DWORD_BY_WORD_DIVIDE);
      ubyte = (dv.op == IDU_UNSIGNED_BYTE_BY_BYTE_DIVIDE);
      // Byte kind sees the low byte only [RQ17]
      if (ubyte)
         a = 34'(dv.dividend[7:0]);
      else if (wide)
         a = sgn ? 34'($signed(dv.dividend)) : 34'(dv.dividend);
      else // Whole word as dividend [RQ2]
         a = sgn ? 34'($signed(dv.dividend[15:0]))
                 : 34'(dv.dividend[15:0]);
      // Divisor is half the destination width [RQ12]
      if (wide)
         b = sgn ? 34'($signed(dv.divisor)) : 34'(dv.divisor);
      else
         b = sgn ? 34'($signed(dv.divisor[7:0]))
                 : 34'(dv.divisor[7:0]);
      // Zero divisor gives a zero result, flagged below
      q = (b == 34'sh0) ? 34'sh0 : a / b;
      r = (b == 34'sh0) ? 34'sh0 : a % b;
      // Overflow by zero divisor or too wide a quotient
      if (b == 34'sh0)
         next_ovf = 1'b1;                              // [RQ7]
      else if (ubyte)
         next_ovf = 1'b0;                              // [RQ7]
      else if (wide)                                   // [RQ10]
         next_ovf = sgn ? (q > 34'sh7fff || q < -34'sh8000)
                        : (q > 34'shffff);
      else                                             // [RQ9]
         next_ovf = sgn ? (q > 34'sh7f || q < -34'sh80)
                        : (q > 34'shff);
   end

   // ==========================================================
   // Result registers
   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         dv.quot <= 16'h0;
         dv.rem  <= 16'h0;
         dv.ovf  <= 1'b0;
      end
      else
      begin
         dv.quot <= q[15:0];
         dv.rem  <= r[15:0];
         dv.ovf  <= next_ovf;
      end
   end
endmodule
`default_nettype wire

// *** verif/idu_host_model.sv ***
`default_nettype none
// ==========================================================
// Register bus master standing in for the core's decoder
module idu_host_model (
   // Clock
   input  wire logic        clk_sys,
   // Write channels
   output logic [5:0]       awaddr,
   output logic             awvalid,
   input  wire logic        awready,
   output logic [31:0]      wdata,
   output logic [3:0]       wstrb,
   output logic             wvalid,
   input  wire logic        wready,
   input  wire logic [1:0]  bresp,
   input  wire logic        bvalid,
   output logic             bready,
   // Read channels
   output logic [5:0]       araddr,
   output logic             arvalid,
   input  wire logic        arready,
   input  wire logic [31:0] rdata,
   input  wire logic [1:0]  rresp,
   input  wire logic        rvalid,
   output logic             rready
);
   timeunit 1ns;
   timeprecision 1ps;
   // Idle bus at time zero
   initial
   begin
      {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
      {araddr, arvalid, rready} = '0;
   end
   // Address and data offered together, each dropped when taken
   task automatic wr(input logic [5:0] a, input logic [31:0] d,
                     output logic [1:0] r);
      @(posedge clk_sys);
      awaddr <= a;
      wdata <= d;
      wstrb <= 4'hf;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      forever
      begin
         @(posedge clk_sys);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid)
         begin
            r = bresp;
            bready <= 1'b0;
            break;
         end
      end
   endtask
   // Read: address held until taken, data captured at rvalid edge
   task automatic rd(input logic [5:0] a, output logic [31:0] d,
                     output logic [1:0] r);
      @(posedge clk_sys);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      forever
      begin
         @(posedge clk_sys);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid)
         begin
            d = rdata;
            r = rresp;
            rready <= 1'b0;
            break;
         end
      end
   endtask
endmodule
`default_nettype wire

// *** verif/idu_top_test.sv ***
`default_nettype none
// ==========================================================
// Divide unit bench
module idu_top_test;
   import idu_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys = 1'b0, nrst = 1'b0;
   logic [5:0] aw, ar;
   logic [31:0] wd, rdt, st;
   logic [3:0] ws;
   logic [1:0] br, rr, rs;
   logic awv, awr, wv, wr_, bv, bry, arv, arr, rv, rry, trp;
   idu_state_t dst;
   int bad_count = 0, cmp_count = 0, runCnt = 0, runLen = 0, trapCnt = 0;
   always #5 clk_sys = ~clk_sys;
   idu_top idu_top_inst (.clk_sys(clk_sys), .nrst(nrst),
      .s_axi_awaddr(aw), .s_axi_awvalid(awv), .s_axi_awready(awr),
      .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
      .s_axi_wready(wr_), .s_axi_bresp(br), .s_axi_bvalid(bv),
      .s_axi_bready(bry), .s_axi_araddr(ar), .s_axi_arvalid(arv),
      .s_axi_arready(arr), .s_axi_rdata(rdt), .s_axi_rresp(rr),
      .s_axi_rvalid(rv), .s_axi_rready(rry), .divState(dst),
      .divTrap(trp));
   idu_host_model idu_host_model_inst (.clk_sys(clk_sys),
      .awaddr(aw), .awvalid(awv), .awready(awr), .wdata(wd),
      .wstrb(ws), .wvalid(wv), .wready(wr_), .bresp(br), .bvalid(bv),
      .bready(bry), .araddr(ar), .arvalid(arv), .arready(arr),
      .rdata(rdt), .rresp(rr), .rvalid(rv), .rready(rry));
   // Length of last busy spell and count of trap pulses
   always @(posedge clk_sys)
   begin
      if (dst === IDU_RUN) runCnt <= runCnt + 1;
      else if (runCnt != 0)
      begin
         runLen <= runCnt;
         runCnt <= 0;
      end
      if (trp === 1'b1) trapCnt <= trapCnt + 1;
   end
   task automatic check(input logic [31:0] seen, exp);
      cmp_count++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   function automatic logic [5:0] ra(input logic [2:0] n);
      return 6'h20 + {1'b0, n, 2'b00};
   endfunction
   task automatic wreg(input logic [5:0] a, input logic [31:0] d);
      idu_host_model_inst.wr(a, d, rs);
      check(32'(rs), 32'h0);
   endtask
   task automatic rreg(input logic [5:0] a, input logic [31:0] e);
      idu_host_model_inst.rd(a, st, rs);
      check(st, e);
   endtask
   // Start a divide, optionally poke it while busy, poll, check flags
   task automatic div(input logic [31:0] cmd, imm, input logic [2:0] len,
      input int n, input logic [3:0] fl, msk, input logic poke);
      wreg(6'h04, imm);
      wreg(6'h00, cmd);
      if (poke)
      begin
         idu_host_model_inst.wr(6'h00, cmd, rs);
         check(32'(rs), 32'h2);
      end
      st = 32'h1;
      for (int i = 0; i < 40 && st[0] !== 1'b0; i++)
         idu_host_model_inst.rd(6'h08, st, rs);
      check(32'(st[10:8]), 32'(len));
      check(32'(st[1]), 32'h0);
      check(32'(st[5:2] & msk), 32'(fl & msk));
      check(32'(runLen), 32'(n - 1));
   endtask
   task automatic close_out;
      $display("mismatches %0d compares %0d", bad_count, cmp_count);
      if (bad_count == 0 && cmp_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // Watchdog well beyond the expected run
   initial
   begin
      repeat (20000) @(posedge clk_sys);
      bad_count++;
      close_out();
   end
   initial
   begin
      repeat (16) @(posedge clk_sys);
      nrst <= 1'b1;
      check(32'(dst), 32'(IDU_IDLE));
      wreg(ra(4), 32'h5564);
      div(32'h48, 32'h7, 3'h3, 12, 4'h0, 4'hf, 1'b0);
      rreg(ra(4), 32'h020e);
      wreg(ra(4), 32'h9);
      div(32'h48, 32'h0, 3'h3, 12, 4'h9, 4'h9, 1'b1);
      check(32'(trapCnt), 32'h1);
      rreg(ra(4), 32'h9);
      wreg(ra(1), 32'hff9c);
      wreg(ra(2), 32'h700);
      div(32'h512, 32'h0, 3'h2, 14, 4'h2, 4'hf, 1'b0);
      rreg(ra(1), 32'hfef2);
      wreg(ra(3), 32'h1000);
      div(32'h39, 32'h2, 3'h3, 12, 4'h1, 4'h9, 1'b0);
      wreg(ra(6), 32'h5);
      wreg(ra(7), 32'h1);
      wreg(ra(0), 32'h10);
      div(32'h63, 32'h0, 3'h2, 22, 4'h0, 4'hf, 1'b0);
      rreg(ra(6), 32'h1000);
      rreg(ra(7), 32'h5);
      wreg(ra(4), 32'hfff0);
      wreg(ra(5), 32'hffff);
      div(32'h4c, 32'h0201, 3'h4, 24, 4'h4, 4'hf, 1'b0);
      rreg(ra(4), 32'h0);
      rreg(ra(5), 32'hfff0);
      div(32'h0a, 32'hfd, 3'h3, 14, 4'h2, 4'hf, 1'b0);
      rreg(ra(0), 32'h01fb);
      wreg(ra(2), 32'h34);
      wreg(ra(3), 32'h12);
      div(32'h3b, 32'h1, 3'h4, 22, 4'h0, 4'hf, 1'b0);
      rreg(ra(2), 32'h1200);
      rreg(ra(3), 32'h34);
      rreg(6'h00, 32'h2b);
      idu_host_model_inst.wr(6'h08, 32'h0, rs);
      check(32'(rs), 32'h2);
      idu_host_model_inst.rd(6'h10, st, rs);
      check(32'(rs), 32'h2);
      check(32'(trapCnt), 32'h1);
      close_out();
   end
endmodule
`default_nettype wire
